// ---- pkg/gpp_pkg.sv ----
// constants and types shared by the parallel port block
package gpp_pkg;

  // port width and byte lanes of the register access port
  localparam int unsigned PORT_W   = 16;
  localparam int unsigned LANE_W   = 8;
  localparam int unsigned LANE_N   = PORT_W / LANE_W;

  // register select codes: word index of each port register
  localparam logic [1:0] SEL_DIR   = 2'h0;
  localparam logic [1:0] SEL_STATE = 2'h1;
  localparam logic [1:0] SEL_LATCH = 2'h2;

  // reset values, plus the all-zero and all-one words
  localparam logic [PORT_W-1:0] LATCH_RST = 16'h0000;
  localparam logic [PORT_W-1:0] RDATA_RST = 16'h0000;
  localparam logic [PORT_W-1:0] ALL_ZERO  = 16'h0000;
  localparam logic [PORT_W-1:0] ALL_ONE   = 16'hFFFF;

  // register selector type
  typedef logic [1:0] gpp_sel_t;

  // port data word
  typedef logic [PORT_W-1:0] gpp_word_t;

endpackage

// ---- verilog/gpp_pad_mux.sv ----
// per-pad output data and enable multiplexers between peripheral and port
`timescale 1ns/10ps

module gpp_pad_mux (
  input  wire gpp_pkg::gpp_word_t impl_mask_i,
  input  wire gpp_pkg::gpp_word_t input_only_mask_i,
  input  wire gpp_pkg::gpp_word_t periph_en_i,
  input  wire gpp_pkg::gpp_word_t periph_drive_i,
  input  wire gpp_pkg::gpp_word_t periph_out_i,
  input  wire gpp_pkg::gpp_word_t port_dir_i,
  input  wire gpp_pkg::gpp_word_t port_latch_i,
  output var  gpp_pkg::gpp_word_t pad_out_o,
  output var  gpp_pkg::gpp_word_t pad_oe_o,
  output var  gpp_pkg::gpp_word_t periph_owns_o
);
  import gpp_pkg::*;

  gpp_word_t periph_sel;
  gpp_word_t port_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // ownership: an enabled peripheral takes the pad only while it drives it;
  // input-only functions never compete, so such pads stay with the port
  assign periph_sel = periph_en_i & periph_drive_i & ~input_only_mask_i & impl_mask_i;

  // port drives only where the direction bit is zero
  assign port_oe = ~port_dir_i & impl_mask_i;

  ////////////////////////////////////////////////////////////////////////////////
  // the two multiplexers per pad: data and output enable
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (periph_sel[i]) begin
        pad_out_o[i] = periph_out_i[i];
        pad_oe_o[i]  = 1'b1;            // port driver is off here
      end else begin
        pad_out_o[i] = port_latch_i[i] & impl_mask_i[i];
        pad_oe_o[i]  = port_oe[i];
      end
    end
  end

  assign periph_owns_o = periph_sel;

endmodule

// ---- verilog/gpp_port.sv ----
// parallel i/o port of up to sixteen pins shared with peripherals
//
// Overview of operation
// - an actively driving enabled peripheral turns the port driver off; pin stays readable
// - an enabled but idle peripheral leaves the pin to the port's latch and direction
// - direction one makes the pin an input, zero makes it an output
// - reset sets every implemented direction bit, so all pins come up as inputs
// - latch reads return stored latch, latch writes update it
// - pin-state reads return pin levels, pin-state writes update the latch
// - unimplemented bit positions are disabled and read as zero everywhere
// - pins shared only with input functions stay fully owned by the port
// - per pad, multiplexers pick peripheral or port for output data and enable

// access port notes
//   selects: direction, pin state, latch, and one spare code that reads zero
//   writes land at the strobe edge, one byte lane per enable bit
//   reads answer a cycle later with a single-cycle valid pulse
//   read and write together: the read returns the value before the write
//   a pin-state read right after a write may still see the old pad level
//   pads and peripheral paths are combinational, so ownership moves at once
//   no pad synchroniser here: pad levels are taken as already synchronous
`timescale 1ns/10ps

module gpp_port #(
  parameter gpp_pkg::gpp_word_t IMPL_MASK       = 16'hFFFF,
  parameter gpp_pkg::gpp_word_t INPUT_ONLY_MASK = 16'h0000
) (
  input  wire  logic               clk_i,
  input  wire  logic               reset_n_i,

  // register access port
  input  wire  gpp_pkg::gpp_sel_t  acc_sel_i,
  input  wire  logic               acc_wr_i,
  input  wire  logic               acc_rd_i,
  input  wire  logic [1:0]         acc_be_i,
  input  wire  gpp_pkg::gpp_word_t acc_wdata_i,
  output var   gpp_pkg::gpp_word_t acc_rdata_o,
  output logic                     acc_rvalid_o,

  // peripherals sharing the pins
  input  wire  gpp_pkg::gpp_word_t periph_en_i,
  input  wire  gpp_pkg::gpp_word_t periph_drive_i,
  input  wire  gpp_pkg::gpp_word_t periph_out_i,
  output var   gpp_pkg::gpp_word_t periph_pin_o,
  output var   gpp_pkg::gpp_word_t periph_owns_o,

  // pad cells
  input  wire  gpp_pkg::gpp_word_t pad_in_i,
  output var   gpp_pkg::gpp_word_t pad_out_o,
  output var   gpp_pkg::gpp_word_t pad_oe_o
);
  import gpp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state of the port

  typedef struct packed {
    gpp_word_t pin_direction_reg;
    gpp_word_t output_latch_reg;
    gpp_word_t rdata;
    logic      rvalid;
  } gpp_state_t;

  // reset image: implemented pins come up as inputs, latch and read port clear
  localparam gpp_state_t ST_RST = '{
    pin_direction_reg: IMPL_MASK,
    output_latch_reg:  LATCH_RST,
    rdata:             RDATA_RST,
    rvalid:            1'b0
  };

  // registered state and its next value
  gpp_state_t st_q;
  gpp_state_t st_d;

  // pad levels and write decode
  gpp_word_t  pin_level;
  gpp_word_t  wr_mask;
  logic       wr_dir;
  logic       wr_at_latch;
  logic       wr_at_state;
  logic       wr_latch;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // unimplemented positions are held at zero wherever a word is stored or read
  function automatic gpp_word_t keep_impl(input gpp_word_t v);
    keep_impl = v & IMPL_MASK;
  endfunction

  // one strobe qualified by one select code, shared by the write decode
  function automatic logic sel_is(input logic     strobe_v,
                                  input gpp_sel_t sel_v,
                                  input gpp_sel_t code_v);
    sel_is = strobe_v && (sel_v == code_v);
  endfunction

  // merge write data under a bit mask, keeping unimplemented bits at zero
  function automatic gpp_word_t merge_bits(input gpp_word_t old_v,
                                           input gpp_word_t new_v,
                                           input gpp_word_t mask_v);
    merge_bits = keep_impl((old_v & ~mask_v) | (new_v & mask_v));
  endfunction

  // expand the byte enables to a bit mask
  function automatic gpp_word_t lane_mask(input logic [1:0] be_v);
    gpp_word_t m;
    m = ALL_ZERO;
    for (int l = 0; l < LANE_N; l++) begin
      if (be_v[l]) begin
        m[l*LANE_W +: LANE_W] = {LANE_W{1'b1}};
      end
    end
    lane_mask = m;
  endfunction

  // read mux: the spare select code reads zero
  function automatic gpp_word_t read_word(input gpp_sel_t  sel_v,
                                          input gpp_word_t dir_v,
                                          input gpp_word_t latch_v,
                                          input gpp_word_t pins_v);
    gpp_word_t r;
    unique case (sel_v)
      SEL_DIR: begin
        r = keep_impl(dir_v);
      end
      SEL_STATE: begin
        r = keep_impl(pins_v); // pad level, not the latch
      end
      SEL_LATCH: begin
        r = keep_impl(latch_v); // latch, not the pads
      end
      default: begin
        r = ALL_ZERO; // unmapped selector reads zero
      end
    endcase
    read_word = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // write decode

  // pins read as their pad level; unimplemented positions forced low
  assign pin_level = keep_impl(pad_in_i);

  // byte lanes and select decode of a write
  assign wr_mask     = lane_mask(acc_be_i);
  assign wr_dir      = sel_is(acc_wr_i, acc_sel_i, SEL_DIR);
  assign wr_at_latch = sel_is(acc_wr_i, acc_sel_i, SEL_LATCH);
  assign wr_at_state = sel_is(acc_wr_i, acc_sel_i, SEL_STATE);

  // both addresses land in the latch; the pads never feed back into it
  assign wr_latch = wr_at_latch || wr_at_state;

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d        = st_q;
    st_d.rvalid = 1'b0;

    // direction register, implemented bits only
    if (wr_dir) begin
      st_d.pin_direction_reg = merge_bits(st_q.pin_direction_reg, acc_wdata_i, wr_mask);
    end

    // latch writes from either address
    if (wr_latch) begin
      st_d.output_latch_reg = merge_bits(st_q.output_latch_reg, acc_wdata_i, wr_mask);
    end

    // read path: registered, so answer comes one cycle after the request;
    // a read in the same cycle as a write returns the old register value
    if (acc_rd_i) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = read_word(acc_sel_i,
                              st_q.pin_direction_reg,
                              st_q.output_latch_reg,
                              pin_level);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  // all implemented pins come up as inputs
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pad multiplexers

  gpp_pad_mux i_gpp_pad_mux (
    .impl_mask_i       (IMPL_MASK),
    .input_only_mask_i (INPUT_ONLY_MASK),
    .periph_en_i       (periph_en_i),
    .periph_drive_i    (periph_drive_i),
    .periph_out_i      (periph_out_i),
    .port_dir_i        (st_q.pin_direction_reg),
    .port_latch_i      (st_q.output_latch_reg),
    .pad_out_o         (pad_out_o),
    .pad_oe_o          (pad_oe_o),
    .periph_owns_o     (periph_owns_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // peripherals always see the pin level, whoever owns the driver
  assign periph_pin_o = pin_level;

  // read port straight from the state register, so no glitches reach the bus
  assign acc_rdata_o  = st_q.rdata;
  assign acc_rvalid_o = st_q.rvalid;

endmodule

// ---- verification/gpp_pin_mdl.sv ----
// far-side pin model: pads read back their own level, floating pins wander
`timescale 1ns/10ps
module gpp_pin_mdl (
  input  wire logic        clk_i,
  input  wire logic [15:0] pad_out_i,
  input  wire logic [15:0] pad_oe_i,
  output logic      [15:0] pad_in_o
);
  logic [15:0] flt_q = 16'hA5C3;
  // no pull on these pins, so a released pin must not keep its last level
  always @(posedge clk_i) begin
    flt_q <= flt_q * 16'h0005 + 16'h3C71;
  end
  // a driven pad is seen on its own input, so the pin stays readable
  assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & flt_q);
endmodule

// ---- verification/gpp_port_chk.sv ----
// boundary assertions for the parallel port
`timescale 1ns/10ps
module gpp_port_chk #(
  parameter logic [15:0] IMPL_MASK       = 16'hFFFF,
  parameter logic [15:0] INPUT_ONLY_MASK = 16'h0000
) (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [1:0]  acc_sel_i,
  input wire logic        acc_wr_i,
  input wire logic        acc_rd_i,
  input wire logic [1:0]  acc_be_i,
  input wire logic [15:0] acc_wdata_i,
  input wire logic [15:0] acc_rdata_o,
  input wire logic        acc_rvalid_o,
  input wire logic [15:0] periph_en_i,
  input wire logic [15:0] periph_drive_i,
  input wire logic [15:0] periph_out_i,
  input wire logic [15:0] periph_pin_o,
  input wire logic [15:0] periph_owns_o,
  input wire logic [15:0] pad_in_i,
  input wire logic [15:0] pad_out_o,
  input wire logic [15:0] pad_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////
  // access steps
  sequence s_dir_wr;
    acc_wr_i && acc_sel_i == 2'h0 && acc_be_i == 2'h3;
  endsequence
  sequence s_pin_rd;
    acc_rd_i && acc_sel_i == 2'h1;
  endsequence
  property p_rd_valid; acc_rd_i |=> acc_rvalid_o; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read gave no valid");
  property p_rd_quiet; !acc_rd_i |=> !acc_rvalid_o && $stable(acc_rdata_o); endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data moved");
  property p_pin_rd; s_pin_rd |=> acc_rdata_o == ($past(pad_in_i) & IMPL_MASK); endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin read wrong");
  property p_unmap; acc_rd_i && acc_sel_i == 2'h3 |=> acc_rdata_o == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // inverted direction word maps straight onto the enables of port-owned pins
  property p_dir; s_dir_wr |=> ((pad_oe_o ^ ~$past(acc_wdata_i)) & IMPL_MASK & ~periph_owns_o) == 16'h0000; endproperty
  a_dir: assert property (p_dir) else $error("enable not from direction");
  ////////////////////////////////////////////////////////////////
  // pad multiplexers
  property p_own; periph_owns_o == (periph_en_i & periph_drive_i & ~INPUT_ONLY_MASK & IMPL_MASK); endproperty
  a_own: assert property (p_own) else $error("ownership wrong");
  property p_mux; ((pad_out_o ^ periph_out_i) & periph_owns_o) == 16'h0000 && (pad_oe_o & periph_owns_o) == periph_owns_o;
  endproperty
  a_mux: assert property (p_mux) else $error("peripheral not on pad");
  property p_unimpl; ((pad_oe_o | periph_pin_o | periph_owns_o) & ~IMPL_MASK) == 16'h0000; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit live");
  property p_view; periph_pin_o == (pad_in_i & IMPL_MASK); endproperty
  a_view: assert property (p_view) else $error("pin view wrong");
endmodule

// ---- verification/gpp_port_tb.sv ----
// self-checking bench for the parallel port
`timescale 1ns/10ps
module gpp_port_tb;
  import gpp_pkg::*;
  localparam gpp_word_t IM = 16'h7FF6;
  localparam gpp_word_t IO = 16'h0100;
  logic      clk_i = 1'b0, reset_n_i = 1'b0, acc_wr_i = 1'b0, acc_rd_i = 1'b0, acc_rvalid_o;
  gpp_sel_t  acc_sel_i = 2'h0;
  logic [1:0] acc_be_i = 2'h0;
  gpp_word_t acc_wdata_i = '0, periph_en_i = '0, periph_drive_i = '0, periph_out_i = '0;
  gpp_word_t acc_rdata_o, periph_pin_o, periph_owns_o, pad_in_i, pad_out_o, pad_oe_o, w, d, e, dir;
  gpp_word_t expq[$];
  int        n_fail = 0, checked = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  gpp_port #(.IMPL_MASK(IM), .INPUT_ONLY_MASK(IO)) i_gpp_port (.*);
  gpp_pin_mdl i_gpp_pin_mdl (.clk_i, .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .pad_in_o(pad_in_i));
  task automatic chk(gpp_word_t s, gpp_word_t x);
    checked++;
    if (s !== x) begin
      n_fail++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, x);
    end
  endtask
  task automatic final_report();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one access per two cycles, so a read never follows a write back to back
  task automatic acc(gpp_sel_t s, logic wr, logic [1:0] be, gpp_word_t wd, logic rd, gpp_word_t x);
    @(posedge clk_i);
    #1;
    {acc_sel_i, acc_wr_i, acc_be_i, acc_wdata_i, acc_rd_i} = {s, wr, be, wd, rd};
    if (rd) expq.push_back(s == SEL_STATE ? pad_in_i & IM : x);
    @(posedge clk_i);
    #1;
    {acc_wr_i, acc_rd_i} = 2'b00;
  endtask
  ////////////////////////////////////////////////////////////////
  // watch read answers and cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 2000) begin
      n_fail++;
      final_report();
    end else begin
      #2;
      if (acc_rvalid_o === 1'b1 && expq.size() == 0) begin
        chk(16'(expq.size()), 16'h0001); // a valid with no read pending
      end else if (acc_rvalid_o === 1'b1) begin
        chk(acc_rdata_o, expq.pop_front());
      end
    end
  end
  initial begin
    void'($urandom(32'h66db948c));
    repeat (12) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    chk(pad_oe_o, ALL_ZERO);
    acc(SEL_DIR, 1'b0, 2'h0, ALL_ZERO, 1'b1, IM);
    acc(SEL_LATCH, 1'b0, 2'h0, ALL_ZERO, 1'b1, LATCH_RST);
    // all outputs, latch loaded through the pin-state register
    w = 16'($urandom);
    acc(SEL_DIR, 1'b1, 2'h3, ALL_ZERO, 1'b0, ALL_ZERO);
    acc(SEL_STATE, 1'b1, 2'h3, w, 1'b0, ALL_ZERO);
    chk(pad_oe_o, IM);
    chk(pad_out_o, w & IM);
    acc(SEL_LATCH, 1'b0, 2'h0, ALL_ZERO, 1'b1, w & IM);
    acc(SEL_STATE, 1'b0, 2'h0, ALL_ZERO, 1'b1, ALL_ZERO);
    // low lane only, then a write and read at the unmapped select
    d = 16'($urandom);
    acc(SEL_LATCH, 1'b1, 2'h1, d, 1'b0, ALL_ZERO);
    acc(2'h3, 1'b1, 2'h3, ALL_ONE, 1'b1, ALL_ZERO);
    w = {w[15:8], d[7:0]} & IM;
    acc(SEL_LATCH, 1'b0, 2'h0, ALL_ZERO, 1'b1, w);
    // random peripheral claims against random directions
    for (int k = 0; k < 8; k++) begin
      dir = 16'($urandom);
      acc(SEL_DIR, 1'b1, 2'h3, dir, 1'b0, ALL_ZERO);
      periph_en_i = 16'($urandom);
      periph_drive_i = 16'($urandom);
      periph_out_i = 16'($urandom);
      #1;
      e = periph_en_i & periph_drive_i & ~IO & IM;
      chk(periph_owns_o, e);
      chk(pad_oe_o, e | (~dir & IM));
      chk(pad_out_o, (e & periph_out_i) | (~e & w));
      chk(periph_pin_o, pad_in_i & IM);
      acc(SEL_STATE, 1'b0, 2'h0, ALL_ZERO, 1'b1, ALL_ZERO);
    end
    repeat (2) @(posedge clk_i);
    // second reset in mid-run: every implemented pin must fall back to input
    #1;
    reset_n_i = 1'b0;
    periph_en_i = ALL_ZERO;
    periph_drive_i = ALL_ZERO;
    @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    chk(pad_oe_o, ALL_ZERO);
    chk(pad_out_o, LATCH_RST);
    acc(SEL_DIR, 1'b0, 2'h0, ALL_ZERO, 1'b1, IM);
    acc(SEL_LATCH, 1'b0, 2'h0, ALL_ZERO, 1'b1, LATCH_RST);
    repeat (2) @(posedge clk_i);
    chk(16'(expq.size()), ALL_ZERO);
    final_report();
  end
endmodule
bind gpp_port gpp_port_chk #(.IMPL_MASK(IMPL_MASK), .INPUT_ONLY_MASK(INPUT_ONLY_MASK)) i_gpp_port_chk (.*);
